// ==== design/ris_pkg.sv ====
/*
 * Constants, register map and state codes for the reset and interrupt
 * sequencer. Assumes a 20 MHz APB clock and an 8-bit APB address.
 */
package ris_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int        CLK_HZ          = 20_000_000;
  localparam int        OSC_DIVIDE      = 4;            // osc rises per system cycle
  localparam logic [1:0] DIV_LAST       = 2'h3;         // OSC_DIVIDE - 1
  localparam logic [1:0] CLEAR_HIGH_CYC = 2'h3;         // address lines high from 3rd cycle
  localparam logic [2:0] PUSH_BYTES     = 3'h7;         // pc, x, a, b, flags

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_VECTOR = 8'h1c;

  localparam int        CTRL_EXT1_BIT = 0;
  localparam int        CTRL_EXT2_BIT = 1;
  localparam int        CTRL_RAM_ENABLE_BIT_BIT = 6;
  localparam logic [7:0] CTRL_RESET   = 8'h40;          // pins as ports, ram on

  // status word layout
  localparam int STAT_PEND_LSB  = 0;                    // 12 pending sources
  localparam int STAT_MODE_LSB  = 16;                   // latched mode pins
  localparam int STAT_STATE_LSB = 24;                   // sequencer state

  // ****************************************************************
  // vectors, highest priority first
  // ****************************************************************
  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] VEC_TRAP    = 16'hffee;
  localparam logic [15:0] VEC_NMI     = 16'hfffc;
  localparam logic [15:0] VEC_SWI     = 16'hfffa;
  localparam logic [15:0] VEC_EXT_REQUEST_ONE    = 16'hfff8;
  localparam logic [15:0] VEC_CAPTURE = 16'hfff6;
  localparam logic [15:0] VEC_COMPARE = 16'hfff4;
  localparam logic [15:0] VEC_OVERFL  = 16'hfff2;
  localparam logic [15:0] VEC_CMATCH  = 16'hffec;
  localparam logic [15:0] VEC_EXT_REQUEST_TWO    = 16'hffea;
  localparam logic [15:0] VEC_SERIAL  = 16'hfff0;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_INIT = 5'h02,
    ST_RUN  = 5'h04,
    ST_PUSH = 5'h08,
    ST_VEC  = 5'h10
  } ris_state_t;

endpackage

// ==== design/ris_sync.sv ====
/*
 * Two-flop synchroniser for a bundle of independent pin levels.
 * Assumes each bit is a slow level; no bus coherence is kept.
 */
`timescale 1ns/1ps
module ris_sync #(
  parameter int        WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== design/ris_sequencer.sv ====
/*
 * Reset, standby and interrupt sequencer: divides the oscillator to the
 * system clock, tracks clear and standby pins, ranks interrupt sources
 * and drives the push / vector-fetch handshake to the cpu core.
 * Assumes the core reports instruction boundaries and its mask flag on
 * pclk, and that software reaches the control word over apb.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// [RULE1] system clock is oscillator divided by four, driven out on a pin
// [RULE2] standby low stops the oscillator and holds all logic in reset
// [RULE3] software clears ram enable bit before standby to keep ram contents; here standby reloads CTRL_RESET, so the bit is set again
// [RULE4] at power-on the clear pin is held low at least 20 ms
// [RULE5] running reset needs the clear pin low at least three system cycles
// [RULE6] from third cleared cycle all address lines high until release
// [RULE7] reset leaves cpu data registers, ram and port data undefined
// [RULE8] on release latch mode pins, init registers, set mask, fetch fffe
// [RULE9] nmi falling edge serviced after current instruction, mask ignored
// [RULE10] nmi pushes all cpu registers then fetches vector fffc
// [RULE11] software sets the stack pointer before any nmi edge
// [RULE12] external requests are levels, taken at boundaries, ignored when masked
// [RULE13] maskable service pushes registers, sets mask, fetches vector last
// [RULE14] control bits 0 and 1 enable the two external request pins
// [RULE15] timer and serial events merge into one internal maskable request
// [RULE16] external request one and input strobe share vector fff8
// [RULE17] capture fff6, compare fff4, overflow fff2, counter match ffec
// [RULE18] serial event ors four flags, vector fff0, lowest priority
// [RULE19] reset clears both external request enables
// [RULE20] fixed priority from reset down to serial, highest served first
// [RULE21] maskable sampling only at boundaries, re-ranked after each service
module ris_sequencer
  import ris_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // pins
  input  wire logic        osc_input,
  input  wire logic        standby_pin_n,
  input  wire logic        system_clear_pin_n,
  input  wire logic        mode_pin_zero,
  input  wire logic        mode_pin_one,
  input  wire logic        non_maskable_request_n,
  input  wire logic        ext_request_one_n,
  input  wire logic        ext_request_two_n,
  output      logic        sys_clock_out,
  output      logic        osc_enable,
  output      logic        addr_all_high,
  // peripheral flags (pclk domain)
  input  wire logic        input_strobe_flag,
  input  wire logic        capture_event,
  input  wire logic [1:0]  compare_event,
  input  wire logic        overflow_event,
  input  wire logic        counter_match_event,
  input  wire logic        rx_full_flag,
  input  wire logic        overrun_framing_flag,
  input  wire logic        tx_empty_flag,
  input  wire logic        parity_error_flag,
  // cpu core handshake (pclk domain)
  input  wire logic        instr_boundary,
  input  wire logic        int_mask,
  input  wire logic        software_interrupt_instr,
  input  wire logic        illegal_fault,
  output      logic        sys_tick,
  output      logic        core_reset,
  output      logic        push_active,
  output      logic        vector_fetch,
  output      logic [15:0] vector_addr,
  output      logic        mask_set,
  output      logic [1:0]  mode_latched,
  output      logic        ram_enable_bit,
  output      logic        ext_one_enable,
  output      logic        ext_two_enable,
  output      logic        internal_request
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0] pins_s;
  logic       osc_s, standby_pin_s, clr_s, mp0_s, mp1_s, nmi_s, ext1_s, ext2_s;

  ris_sync #(.WIDTH(8), .INIT(8'hfe)) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({ext_request_two_n, ext_request_one_n, non_maskable_request_n,
               mode_pin_one, mode_pin_zero, system_clear_pin_n, standby_pin_n,
               osc_input}),
    .q       (pins_s)
  );

  assign {ext2_s, ext1_s, nmi_s, mp1_s, mp0_s, clr_s, standby_pin_s, osc_s} = pins_s;

  // ****************************************************************
  // oscillator divider
  // ****************************************************************
  logic       osc_prev;
  logic [1:0] div_cnt;
  logic       osc_rise;

  assign osc_rise = osc_s & ~osc_prev;

  // [RULE2] oscillator stopped in standby
  assign osc_enable = standby_pin_s;

  // [RULE1] divide by four, clock pin out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev      <= 1'b0;
      div_cnt       <= 2'h0;
      sys_clock_out <= 1'b0;
      sys_tick      <= 1'b0;
    end else if (!standby_pin_s) begin
      osc_prev      <= 1'b0;
      div_cnt       <= 2'h0;
      sys_clock_out <= 1'b0;
      sys_tick      <= 1'b0;
    end else begin
      osc_prev <= osc_s;
      sys_tick <= osc_rise && (div_cnt == DIV_LAST);
      if (osc_rise) begin
        div_cnt       <= div_cnt + 2'h1;
        sys_clock_out <= div_cnt[0] ? ~div_cnt[1] : div_cnt[1];
      end
    end
  end

  // ****************************************************************
  // clear pin and address forcing
  // ****************************************************************
  logic       hold;
  logic [1:0] clr_cnt;

  // [RULE2] standby also holds the reset condition
  assign hold = ~standby_pin_s | ~clr_s;

  // [RULE6] third low cycle drives addresses high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_cnt       <= 2'h0;
      addr_all_high <= 1'b0;
    end else if (!hold) begin
      clr_cnt       <= 2'h0;
      addr_all_high <= 1'b0;
    end else if (sys_tick && clr_cnt != CLEAR_HIGH_CYC) begin
      clr_cnt       <= clr_cnt + 2'h1;
      addr_all_high <= (clr_cnt + 2'h1 == CLEAR_HIGH_CYC);
    end
  end

  // ****************************************************************
  // control register and apb slave
  // ****************************************************************
  logic [7:0]  ctrl;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] status_word;
  ris_state_t  state;

  assign pready  = 1'b1;                       // zero wait states
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_VECTOR);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && (paddr == ADDR_CTRL);

  // [RULE19] reset clears request enables
  // [RULE14] software steers the pin enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (hold) begin
      ctrl <= CTRL_RESET;
    end else if (wr_en) begin
      ctrl <= pwdata[7:0];
    end
  end

  // [RULE3] ram enable handed to the ram block
  assign ram_enable_bit = ctrl[CTRL_RAM_ENABLE_BIT_BIT];
  assign ext_one_enable = ctrl[CTRL_EXT1_BIT];
  assign ext_two_enable = ctrl[CTRL_EXT2_BIT];

  // registered read data, unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL:   prdata <= {24'h00_0000, ctrl};
        ADDR_STATUS: prdata <= status_word;
        ADDR_VECTOR: prdata <= {16'h0000, vector_addr};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // pending sources
  // ****************************************************************
  logic nmi_prev, nmi_pend, trap_pend, swi_pend;
  logic serial_event, ext_request_one_req, ext_request_two_req;
  logic clr_nmi, clr_trap, clr_swi;

  // [RULE18] serial flags merged
  assign serial_event = rx_full_flag | overrun_framing_flag |
                        tx_empty_flag | parity_error_flag;
  // [RULE15] internal sources merged
  assign internal_request = capture_event | (|compare_event) | overflow_event |
                            counter_match_event | serial_event;
  // [RULE12] level requests, gated by enables
  assign ext_request_one_req = ~ext1_s & ext_one_enable;
  assign ext_request_two_req = ~ext2_s & ext_two_enable;

  // [RULE9] falling edge latched; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev  <= 1'b1;
      nmi_pend  <= 1'b0;
      trap_pend <= 1'b0;
      swi_pend  <= 1'b0;
    end else if (hold) begin
      nmi_prev  <= 1'b1;
      nmi_pend  <= 1'b0;
      trap_pend <= 1'b0;
      swi_pend  <= 1'b0;
    end else begin
      nmi_prev  <= nmi_s;
      nmi_pend  <= (nmi_prev & ~nmi_s) | (nmi_pend & ~clr_nmi);
      trap_pend <= illegal_fault | (trap_pend & ~clr_trap);
      swi_pend  <= software_interrupt_instr | (swi_pend & ~clr_swi);
    end
  end

  // ****************************************************************
  // priority ranking
  // ****************************************************************
  logic        found;
  logic [15:0] sel_vec;
  logic        maskok;

  assign maskok = ~int_mask;

  // [RULE20] fixed ranking, highest first
  // [RULE16] shared vector for request one and strobe
  // [RULE17] timer vectors in order
  always_comb begin
    found   = 1'b1;
    sel_vec = VEC_TRAP;
    if (trap_pend) begin
      sel_vec = VEC_TRAP;
    end else if (nmi_pend) begin
      sel_vec = VEC_NMI;
    end else if (swi_pend) begin
      sel_vec = VEC_SWI;
    end else if (maskok && (ext_request_one_req || input_strobe_flag)) begin
      sel_vec = VEC_EXT_REQUEST_ONE;
    end else if (maskok && capture_event) begin
      sel_vec = VEC_CAPTURE;
    end else if (maskok && (|compare_event)) begin
      sel_vec = VEC_COMPARE;
    end else if (maskok && overflow_event) begin
      sel_vec = VEC_OVERFL;
    end else if (maskok && counter_match_event) begin
      sel_vec = VEC_CMATCH;
    end else if (maskok && ext_request_two_req) begin
      sel_vec = VEC_EXT_REQUEST_TWO;
    end else if (maskok && serial_event) begin
      sel_vec = VEC_SERIAL;
    end else begin
      found = 1'b0;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  logic       take;
  logic [2:0] push_cnt;

  // [RULE21] only at a boundary, in the run state
  assign take     = sys_tick && (state == ST_RUN) && instr_boundary && found;
  assign clr_nmi  = take && (sel_vec == VEC_NMI);
  assign clr_trap = take && (sel_vec == VEC_TRAP);
  assign clr_swi  = take && (sel_vec == VEC_SWI);

  // [RULE7] only sequencing state is reset; core data is left alone
  assign core_reset   = (state == ST_HOLD) || (state == ST_INIT);
  assign push_active  = (state == ST_PUSH);
  assign vector_fetch = (state == ST_VEC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ST_HOLD;
      push_cnt     <= 3'h0;
      vector_addr  <= VEC_RESET;
      mask_set     <= 1'b0;
      mode_latched <= 2'h0;
    end else if (hold) begin
      state       <= ST_HOLD;
      push_cnt    <= 3'h0;
      vector_addr <= VEC_RESET;
      mask_set    <= 1'b0;
    end else begin
      mask_set <= 1'b0;
      if (sys_tick) begin
        case (state)
          ST_HOLD: begin
            state <= ST_INIT;
          end
          // [RULE8] latch mode, set mask, reset vector
          ST_INIT: begin
            mode_latched <= {mp1_s, mp0_s};
            mask_set     <= 1'b1;
            vector_addr  <= VEC_RESET;
            state        <= ST_VEC;
          end
          ST_RUN: begin
            if (take) begin
              vector_addr <= sel_vec;
              push_cnt    <= 3'h0;
              state       <= ST_PUSH;
            end
          end
          // [RULE10] push all registers first
          // [RULE13] mask set as the vector is fetched
          ST_PUSH: begin
            push_cnt <= push_cnt + 3'h1;
            if (push_cnt == PUSH_BYTES - 3'h1) begin
              mask_set <= 1'b1;
              state    <= ST_VEC;
            end
          end
          ST_VEC: begin
            state <= ST_RUN;
          end
          default: begin
            state <= ST_HOLD;
          end
        endcase
      end
    end
  end

  // status: pending sources, mode, state
  assign status_word = {3'h0, state, 6'h00, mode_latched, 4'h0,
                        serial_event, ext_request_two_req, counter_match_event,
                        overflow_event, compare_event, capture_event,
                        input_strobe_flag, ext_request_one_req, swi_pend, nmi_pend,
                        trap_pend};

endmodule

// ==== bench/ris_seq_monitor.sv ====
/*
 * Checker for the reset and interrupt sequencer, watching top ports only.
 * Bound into every sequencer instance from the testbench top file.
 */
`timescale 1ns/1ps
module ris_seq_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       system_clear_pin_n,
  input wire logic       sys_tick,
  input wire logic       core_reset,
  input wire logic       addr_all_high,
  input wire logic       push_active,
  input wire logic       vector_fetch,
  input wire logic       mask_set,
  input wire logic       ext_one_enable,
  input wire logic       ext_two_enable,
  input wire logic       internal_request,
  input wire logic       capture_event,
  input wire logic [1:0] compare_event,
  input wire logic       overflow_event,
  input wire logic       counter_match_event,
  input wire logic       rx_full_flag,
  input wire logic       overrun_framing_flag,
  input wire logic       tx_empty_flag,
  input wire logic       parity_error_flag
);
  // one clock domain, so one default for all
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ******
  // clock and hold
  // ******
  // four synced osc rises need at least eight clocks
  tick_gap_a: assert property (sys_tick |=> !sys_tick [*7])
    else $error("system ticks closer than eight clocks");
  clear_hold_a: assert property (!system_clear_pin_n [*5] |-> core_reset)
    else $error("clear pin low but core not held");
  addr_in_hold_a: assert property (addr_all_high |-> core_reset)
    else $error("address lines high outside hold");
  addr_late_a: assert property ($rose(addr_all_high) |-> $past(core_reset, 16))
    else $error("address lines high before third system cycle");
  addr_drop_a: assert property ($fell(core_reset) |-> !addr_all_high)
    else $error("address lines still high after release");
  enables_off_a: assert property (core_reset && $past(core_reset) |->
      !ext_one_enable && !ext_two_enable)
    else $error("request pin enabled during hold");

  // ******
  // service sequence
  // ******
  fetch_after_push_a: assert property ($fell(push_active) |-> vector_fetch)
    else $error("push not followed by vector fetch");
  mask_on_fetch_a: assert property ($rose(vector_fetch) |-> ##[0:1] mask_set)
    else $error("mask not set at vector fetch");
  take_on_tick_a: assert property ($rose(push_active) |-> $past(sys_tick))
    else $error("service taken off a system tick");
  // seven ticks of sixteen clocks with the bench oscillator
  push_len_a: assert property ($rose(push_active) |->
      ##111 push_active ##1 !push_active)
    else $error("push sequence not seven system cycles long");
  merge_or_a: assert property (internal_request == (capture_event || (|compare_event)
      || overflow_event || counter_match_event || rx_full_flag
      || overrun_framing_flag || tx_empty_flag || parity_error_flag))
    else $error("internal request not the or of events");
endmodule

// ==== bench/ris_partner.sv ====
/*
 * Model of the reset circuit, standby switch, crystal and nmi source.
 * Driven by task calls from the testbench; pclk is the bench clock.
 */
`timescale 1ns/1ps
module ris_partner #(
  parameter int POWER_ON_CYC = 64
) (
  input  wire logic pclk,
  output logic      osc_input,
  output logic      standby_pin_n,
  output logic      system_clear_pin_n,
  output logic      non_maskable_request_n
);
  localparam int SYS_PCLK = 16; // osc period 4 clocks, divided by four
  logic [1:0] osc_cnt;

  initial begin
    osc_cnt = 2'h0;
    osc_input = 1'b0;
    standby_pin_n = 1'b1;
    system_clear_pin_n = 1'b0;
    non_maskable_request_n = 1'b1;
    repeat (POWER_ON_CYC) @(posedge pclk);
    system_clear_pin_n <= 1'b1;
  end

  // crystal stands still in standby; slow enough for a two-flop sync
  always @(posedge pclk) begin
    if (standby_pin_n) begin
      osc_cnt <= osc_cnt + 2'h1;
      osc_input <= osc_cnt[1];
    end
  end

  task automatic clear_pulse(input int cyc);
    @(posedge pclk);
    system_clear_pin_n <= 1'b0;
    repeat ((cyc < 3 ? 3 : cyc) * SYS_PCLK) @(posedge pclk);
    system_clear_pin_n <= 1'b1;
  endtask

  // standby level for a number of system cycles
  task automatic standby(input int cyc);
    @(posedge pclk);
    standby_pin_n <= 1'b0;
    repeat (cyc * SYS_PCLK) @(posedge pclk);
    standby_pin_n <= 1'b1;
  endtask

  task automatic nmi_edge();
    @(posedge pclk);
    non_maskable_request_n <= 1'b0;
    repeat (8) @(posedge pclk);
    non_maskable_request_n <= 1'b1;
  endtask
endmodule

// ==== bench/testbench.sv ====
/*
 * Self-checking bench for the reset and interrupt sequencer.
 * Assumes the partner model for the pins and the bound port checker.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAIT(c) begin for (wn = 0; wn < 4000 && !(c); wn++) @(negedge pclk); \
  if (!(c)) begin fails++; give_verdict(); end end
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, err, pready, pslverr, prev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, w, seed;
  logic        osc_input, standby_pin_n, system_clear_pin_n, non_maskable_request_n;
  logic        mode_pin_zero, mode_pin_one, ext_request_one_n, ext_request_two_n;
  logic        input_strobe_flag, capture_event, overflow_event, counter_match_event;
  logic [1:0]  compare_event, mode_latched;
  logic        rx_full_flag, overrun_framing_flag, tx_empty_flag, parity_error_flag;
  logic        instr_boundary, int_mask, software_interrupt_instr, illegal_fault;
  logic        sys_clock_out, osc_enable, addr_all_high, sys_tick, core_reset;
  logic        push_active, vector_fetch, mask_set, ram_enable_bit;
  logic        ext_one_enable, ext_two_enable, internal_request;
  logic [15:0] vector_addr;
  logic [11:0] src, s;
  int          fails, n_checks, wn, seen, i, g;
  // level sources, grouped by vector in falling priority
  localparam logic [11:0] GRP [7] = '{12'h003, 12'h004, 12'h018, 12'h020,
                                      12'h040, 12'h080, 12'hf00};
  localparam logic [15:0] VEC [7] = '{16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2,
                                      16'hffec, 16'hffea, 16'hfff0};

  // one source word fans out to all level request inputs
  assign ext_request_one_n = ~src[0];
  assign input_strobe_flag = src[1];
  assign capture_event = src[2];
  assign compare_event = src[4:3];
  assign overflow_event = src[5];
  assign counter_match_event = src[6];
  assign ext_request_two_n = ~src[7];
  assign {parity_error_flag, tx_empty_flag, overrun_framing_flag, rx_full_flag} = src[11:8];

  ris_sequencer DUT (.*);
  ris_partner partner (.*);

  always #25 pclk = ~pclk;

  // xorshift, fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // highest pending group
  function automatic int top(input logic [11:0] v);
    for (int k = 0; k < 7; k++) if ((v & GRP[k]) != 12'h000) return k;
    return 7;
  endfunction

  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // apb transfer; held until pready seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin fails++; give_verdict(); end
  endtask

  // serve every pending level source, highest first
  task automatic drain();
    while (s != 12'h000) begin
      g = top(s);
      `WAIT(vector_fetch === 1'b1)
      `CHK(internal_request, |(s & 12'hf7c))
      `CHK(vector_addr, VEC[g])
      @(posedge pclk);
      s = s & ~GRP[g];
      src <= s;
      `WAIT(vector_fetch === 1'b0)
    end
  endtask

  // count pushes over a while; sampled off the edge so updates have landed
  task automatic quiet();
    seen = 0;
    repeat (100) begin
      @(negedge pclk);
      if (push_active !== 1'b0) seen++;
    end
  endtask

  initial begin
    seed = 32'h2eee;
    fails = 0;
    n_checks = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 12'h000;
    instr_boundary = 1'b1;
    int_mask = 1'b0;
    software_interrupt_instr = 1'b0;
    illegal_fault = 1'b0;
    w = rnd();
    mode_pin_zero = w[0];
    mode_pin_one = w[1];
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `WAIT(vector_fetch === 1'b1)
    `CHK(vector_addr, 16'hfffe)
    `CHK(mode_latched, {mode_pin_one, mode_pin_zero})
    `WAIT(core_reset === 1'b0)
    // ten system cycles fit exactly in 160 clocks
    seen = 0;
    for (i = 0; i < 160; i++) begin
      prev = sys_clock_out;
      @(negedge pclk);
      if (prev === 1'b0 && sys_clock_out === 1'b1) seen++;
    end
    `CHK(seen, 10)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h00000040)
    apb(1'b0, 8'h30, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    w = rnd();
    apb(1'b1, 8'h14, w);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd, {24'h0, w[7:0]})
    `CHK({ext_two_enable, ext_one_enable}, w[1:0])
    `CHK(ram_enable_bit, w[6])
    apb(1'b1, 8'h14, 32'h43);
    // random mixes of pending sources, all raised at once
    for (i = 0; i < 8; i++) begin
      rd = rnd();
      s = (i == 0) ? 12'hfff : rd[11:0];
      // raise just after a tick, so synced pins are ranked with the rest
      `WAIT(sys_tick === 1'b1)
      @(posedge pclk);
      src <= s;
      drain();
    end
    // masked: capture waits, nmi, trap and swi still go
    @(posedge pclk);
    int_mask <= 1'b1;
    src <= 12'h004;
    quiet();
    `CHK(seen, 0)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(rd, {3'h0, 5'h04, 6'h00, mode_pin_one, mode_pin_zero, 16'h0020})
    partner.nmi_edge();
    `WAIT(vector_fetch === 1'b1)
    `CHK(vector_addr, 16'hfffc)
    `WAIT(vector_fetch === 1'b0)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK(rd, 32'h0000fffc)
    @(posedge pclk);
    software_interrupt_instr <= 1'b1;
    illegal_fault <= 1'b1;
    @(posedge pclk);
    software_interrupt_instr <= 1'b0;
    illegal_fault <= 1'b0;
    `WAIT(vector_fetch === 1'b1)
    `CHK(vector_addr, 16'hffee)
    `WAIT(vector_fetch === 1'b0)
    `WAIT(vector_fetch === 1'b1)
    `CHK(vector_addr, 16'hfffa)
    `WAIT(vector_fetch === 1'b0)
    @(posedge pclk);
    int_mask <= 1'b0;
    s = 12'h004;
    drain();
    // pins read as ports while their enables are clear
    apb(1'b1, 8'h14, 32'h40);
    @(posedge pclk);
    src <= 12'h081;
    quiet();
    `CHK(seen, 0)
    @(posedge pclk);
    src <= 12'h000;
    fork
      partner.clear_pulse(4);
      begin
        `WAIT(addr_all_high === 1'b1)
        `CHK(core_reset, 1'b1)
      end
    join
    `WAIT(vector_fetch === 1'b1)
    `CHK(vector_addr, 16'hfffe)
    `WAIT(core_reset === 1'b0)
    `CHK(addr_all_high, 1'b0)
    apb(1'b1, 8'h14, 32'h00);
    fork
      partner.standby(3);
      begin
        `WAIT(osc_enable === 1'b0)
        repeat (3) @(negedge pclk);
        `CHK(core_reset, 1'b1)
      end
    join
    `WAIT(core_reset === 1'b0)
    give_verdict();
  end
endmodule

bind ris_sequencer ris_seq_monitor u_mon (.*);
